// File: design/evc_pkg.sv
// Constants, types and register map of the stereo encoder volume control.
// Assumes a single 25 MHz clock and an AXI4-Lite master reaching the registers.
`default_nettype none
package evc_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int DEBOUNCE_MS = 20;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int TIMEOUT_MS = 32;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 20;
  // Wiper positions: n means -2n dB, the last code is mute
  localparam logic [5:0] POS_LOUDEST = 6'h00;
  localparam logic [5:0] POS_QUIETEST = 6'h1F;
  localparam logic [5:0] POS_MUTE = 6'h20;
  localparam logic [5:0] POS_POR = 6'h06;
  localparam logic signed [5:0] OFF_LIMIT = 6'sh1F;
  // Volume bar thresholds, first position of each darker band
  localparam logic [5:0] BAR_T4 = 6'h05;
  localparam logic [5:0] BAR_T3 = 6'h0A;
  localparam logic [5:0] BAR_T2 = 6'h0F;
  localparam logic [5:0] BAR_T1 = 6'h14;
  localparam logic [5:0] BAR_T0 = 6'h1B;
  // Gray sequence of the encoder in increasing order
  localparam logic [1:0] GRAY0 = 2'h0;
  localparam logic [1:0] GRAY1 = 2'h1;
  localparam logic [1:0] GRAY2 = 2'h3;
  localparam logic [1:0] GRAY3 = 2'h2;
  // Register byte offsets and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WIPER = 8'h08;
  localparam int CTRL_ENC_DIS = 0;
  localparam int CTRL_BTN_DIS = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic {MODE_VOLUME, MODE_BALANCE} evc_mode_t;
  typedef struct packed {
    logic [5:0] ch1;
    logic [5:0] ch0;
  } evc_wiper_pair_t;
endpackage : evc_pkg
`default_nettype wire

// File: design/evc_top.sv
// Encoder and pushbutton front end, mode logic and clickless wiper stepping
// for a dual 32-tap log attenuator, with AXI4-Lite control and status.
// Assumes pins are asynchronous with pull-ups; LED pins are open drain.
// Contract
// - Mode push toggles volume and balance
// - Each Gray state change gives one step
// - Up count: louder, or balance toward ch1
// - Down count: quieter, or balance toward ch0
// - Volume steps move both wipers together
// - Ignore increase at loudest tap, keep offset
// - At quietest tap, other wiper keeps moving
// - Increase after collapse restores offset
// - Both at 31 plus down gives mute
// - Positions 0..32, 2 dB steps, 32 mute
// - Balance keeps volume, shifts offset
// - Per-channel zero-cross commit or 32 ms
// - Second wiper follows within 32 ms
// - Reset: volume mode, mute, then -12 dB
// - Sleep saves settings, wipers to low end
// - Mute push toggles mute, restores positions
// - Up count while muted cancels mute
// - Indicator sinks while in balance mode
// - Five-LED bar by volume band
// - Balance mode lights exactly one LED
// - Balance LED walks from center outward
// - Both buttons together act on neither
// - Low sleep request holds shutdown
`default_nettype none
module evc_top #(
  parameter int DEBOUNCE_CYCLES = evc_pkg::DEBOUNCE_CYC,
  parameter int TIMEOUT_CYCLES = evc_pkg::TIMEOUT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic encoder_phase_a,
  input wire logic encoder_phase_b,
  input wire logic mode_button_n,
  input wire logic mute_button_n,
  input wire logic sleep_request_n,
  input wire logic [1:0] zero_cross,
  output logic balance_indicator_n_o,
  output logic balance_indicator_n_oe,
  output logic [4:0] level_bar_n_o,
  output logic [4:0] level_bar_n_oe,
  output evc_pkg::evc_wiper_pair_t wiper_pos,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import evc_pkg::*;

  logic [3:0] sync1_reg, sync2_reg, stable_reg, stable_d_reg;
  logic [CNT_W-1:0] db_cnt_reg [4];
  logic [1:0] zc1_reg, zc2_reg;
  logic sleep1_reg, sleep2_reg, shutdown_reg;
  evc_mode_t mode_reg;
  logic mute_reg, collapsed_reg;
  logic [5:0] base_reg;
  logic signed [5:0] off_reg;
  logic [5:0] wiper_reg [2];
  logic [5:0] des [2];
  logic [CNT_W-1:0] tmr_reg [2];
  logic [1:0] ctrl_reg;
  logic step_up, step_dn, both_held, active, mode_press, mute_press;
  logic [1:0] gray_prev, gray_cur;
  logic [5:0] atten0, atten1;
  logic [6:0] sum0, sum1;
  logic [4:0] bar_on, bal_on;
  logic [5:0] loud;

  // Pins enter through two flops; the pull-ups make idle high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
    end else begin
      sync1_reg <= {mute_button_n, mode_button_n, encoder_phase_b, encoder_phase_a};
      sync2_reg <= sync1_reg;
    end
  end

  // A level is accepted only after it stayed put for the whole window
  for (genvar gi = 0; gi < 4; gi++) begin : g_debounce
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        db_cnt_reg[gi] <= '0;
        stable_reg[gi] <= 1'b1;
      end else if (sync2_reg[gi] == stable_reg[gi]) begin
        db_cnt_reg[gi] <= '0;
      end else if (db_cnt_reg[gi] == CNT_W'(DEBOUNCE_CYCLES - 1)) begin
        stable_reg[gi] <= sync2_reg[gi];
        db_cnt_reg[gi] <= '0;
      end else begin
        db_cnt_reg[gi] <= db_cnt_reg[gi] + 1'b1;
      end
    end
  end

  // Previous accepted levels, for edge and direction detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stable_d_reg <= 4'hF;
    end else begin
      stable_d_reg <= stable_reg;
    end
  end

  // Zero-cross flags and sleep request are asynchronous levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zc1_reg <= 2'h0;
      zc2_reg <= 2'h0;
      sleep1_reg <= 1'b1;
      sleep2_reg <= 1'b1;
      shutdown_reg <= 1'b0;
    end else begin
      zc1_reg <= zero_cross;
      zc2_reg <= zc1_reg;
      sleep1_reg <= sleep_request_n;
      sleep2_reg <= sleep1_reg;
      shutdown_reg <= ~sleep2_reg;
    end
  end

  // Direction from the Gray pair; a skipped state is a glitch and gives nothing
  assign gray_prev = stable_d_reg[1:0];
  assign gray_cur = stable_reg[1:0];
  assign both_held = ~stable_reg[2] & ~stable_reg[3];
  assign active = ~shutdown_reg & ~both_held;
  always_comb begin
    step_up = 1'b0;
    step_dn = 1'b0;
    if (gray_prev != gray_cur && active && !ctrl_reg[CTRL_ENC_DIS]) begin
      step_up = (gray_prev == GRAY0 && gray_cur == GRAY1)
        || (gray_prev == GRAY1 && gray_cur == GRAY2)
        || (gray_prev == GRAY2 && gray_cur == GRAY3)
        || (gray_prev == GRAY3 && gray_cur == GRAY0);
      step_dn = (gray_prev == GRAY1 && gray_cur == GRAY0)
        || (gray_prev == GRAY2 && gray_cur == GRAY1)
        || (gray_prev == GRAY3 && gray_cur == GRAY2)
        || (gray_prev == GRAY0 && gray_cur == GRAY3);
    end
  end

  // A press counts only while the other button is up
  assign mode_press = stable_d_reg[2] & ~stable_reg[2] & stable_reg[3]
    & active & ~ctrl_reg[CTRL_BTN_DIS];
  assign mute_press = stable_d_reg[3] & ~stable_reg[3] & stable_reg[2]
    & active & ~ctrl_reg[CTRL_BTN_DIS];

  // Volume or balance mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= MODE_VOLUME;
    end else if (mode_press) begin
      mode_reg <= (mode_reg == MODE_VOLUME) ? MODE_BALANCE : MODE_VOLUME;
    end
  end

  // Mute; a push while collapsed below tap 31 only lifts the collapse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mute_reg <= 1'b0;
    end else if (mute_press && !collapsed_reg) begin
      mute_reg <= ~mute_reg;
    end else if (step_up && mute_reg) begin
      mute_reg <= 1'b0;
    end
  end

  // Louder-channel position plus signed offset; clipping at 31 keeps the
  // offset in memory, so collapsing and reopening needs only collapsed_reg
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_reg <= POS_POR;
      off_reg <= '0;
      collapsed_reg <= 1'b0;
    end else if (mute_press && collapsed_reg) begin
      collapsed_reg <= 1'b0;
    end else if (!mute_reg && mode_reg == MODE_VOLUME) begin
      if (step_up) begin
        if (collapsed_reg) begin
          collapsed_reg <= 1'b0;
        end else if (base_reg != POS_LOUDEST) begin
          base_reg <= base_reg - 1'b1;
        end
      end else if (step_dn) begin
        if (base_reg == POS_QUIETEST) begin
          collapsed_reg <= 1'b1;
        end else begin
          base_reg <= base_reg + 1'b1;
        end
      end
    end else if (!mute_reg && !collapsed_reg) begin
      if (step_up && off_reg != -OFF_LIMIT) begin
        off_reg <= off_reg - 1'b1;
      end else if (step_dn && off_reg != OFF_LIMIT) begin
        off_reg <= off_reg + 1'b1;
      end
    end
  end

  // Targets: extra attenuation per channel clipped at the quietest tap
  assign atten0 = (off_reg < 0) ? 6'(-off_reg) : 6'h00;
  assign atten1 = (off_reg > 0) ? 6'(off_reg) : 6'h00;
  assign sum0 = {1'b0, base_reg} + {1'b0, atten0};
  assign sum1 = {1'b0, base_reg} + {1'b0, atten1};
  always_comb begin
    des[0] = (sum0 > {1'b0, POS_QUIETEST}) ? POS_QUIETEST : sum0[5:0];
    des[1] = (sum1 > {1'b0, POS_QUIETEST}) ? POS_QUIETEST : sum1[5:0];
    if (shutdown_reg || mute_reg || collapsed_reg) begin
      des[0] = POS_MUTE;
      des[1] = POS_MUTE;
    end
  end

  // Each wiper waits for its own zero cross; the timer bounds the wait,
  // so the lagging channel of a stereo step also follows within it
  for (genvar gc = 0; gc < 2; gc++) begin : g_wiper
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        wiper_reg[gc] <= POS_MUTE;
        tmr_reg[gc] <= '0;
      end else if (wiper_reg[gc] == des[gc]) begin
        tmr_reg[gc] <= '0;
      end else if (zc2_reg[gc] || tmr_reg[gc] == CNT_W'(TIMEOUT_CYCLES - 1)) begin
        wiper_reg[gc] <= des[gc];
        tmr_reg[gc] <= '0;
      end else begin
        tmr_reg[gc] <= tmr_reg[gc] + 1'b1;
      end
    end
  end
  assign wiper_pos.ch0 = wiper_reg[0];
  assign wiper_pos.ch1 = wiper_reg[1];

  // Bar from the louder wiper actually set; one-hot balance position
  assign loud = (wiper_reg[0] < wiper_reg[1]) ? wiper_reg[0] : wiper_reg[1];
  always_comb begin
    bar_on = 5'h00;
    if (loud < BAR_T4) bar_on = 5'h1F;
    else if (loud < BAR_T3) bar_on = 5'h0F;
    else if (loud < BAR_T2) bar_on = 5'h07;
    else if (loud < BAR_T1) bar_on = 5'h03;
    else if (loud < BAR_T0) bar_on = 5'h01;
    bal_on = 5'h04;
    if (off_reg < 0 && des[0] == POS_QUIETEST) bal_on = 5'h10;
    else if (off_reg < 0) bal_on = 5'h08;
    else if (off_reg > 0 && des[1] == POS_QUIETEST) bal_on = 5'h01;
    else if (off_reg > 0) bal_on = 5'h02;
  end

  // Open-drain pins always drive low; the enable says when they sink
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_bar_n_oe <= 5'h00;
      balance_indicator_n_oe <= 1'b0;
    end else begin
      level_bar_n_oe <= (mode_reg == MODE_BALANCE) ? bal_on : bar_on;
      balance_indicator_n_oe <= (mode_reg == MODE_BALANCE);
    end
  end
  assign level_bar_n_o = 5'h00;
  assign balance_indicator_n_o = 1'b0;

  // AXI4-Lite write: address and data caught in either order
  logic aw_hold_reg, w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic w_lane0_reg;
  assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_reg & ~s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_lane0_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
      ctrl_reg <= CTRL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_lane0_reg <= s_axi_wstrb[0];
      end
      if (aw_hold_reg && w_hold_reg) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg[7:2] == REG_CTRL[7:2]) ? AXI_OKAY : AXI_SLVERR;
        if (aw_addr_reg[7:2] == REG_CTRL[7:2] && w_lane0_reg) begin
          ctrl_reg <= w_data_reg[1:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read: one beat, answered the cycle after the address
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= AXI_OKAY;
      unique case (s_axi_araddr[7:2])
        REG_CTRL[7:2]: s_axi_rdata <= {30'h0, ctrl_reg};
        REG_STATUS[7:2]: s_axi_rdata <= {26'h0, wiper_reg[1] != des[1],
          wiper_reg[0] != des[0], collapsed_reg, shutdown_reg, mute_reg, mode_reg};
        REG_WIPER[7:2]: s_axi_rdata <= {2'h0, off_reg, 2'h0, base_reg, 2'h0,
          wiper_reg[1], 2'h0, wiper_reg[0]};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks on the behaviour above
  property p_mode_toggle;
    @(posedge aclk) disable iff (!aresetn) mode_press |=> mode_reg != $past(mode_reg);
  endproperty
  a_mode_toggle: assert property (p_mode_toggle) else $error("mode did not toggle");
  property p_vol_up;
    @(posedge aclk) disable iff (!aresetn)
      step_up && mode_reg == MODE_VOLUME && !mute_reg && !collapsed_reg && !mute_press
      && base_reg != POS_LOUDEST |=> base_reg == $past(base_reg) - 1'b1 && $stable(off_reg);
  endproperty
  a_vol_up: assert property (p_vol_up) else $error("volume up step wrong");
  property p_vol_dn;
    @(posedge aclk) disable iff (!aresetn)
      step_dn && mode_reg == MODE_VOLUME && !mute_reg && !collapsed_reg && !mute_press
      && base_reg != POS_QUIETEST |=> base_reg == $past(base_reg) + 1'b1;
  endproperty
  a_vol_dn: assert property (p_vol_dn) else $error("volume down step wrong");
  property p_loudest;
    @(posedge aclk) disable iff (!aresetn)
      step_up && mode_reg == MODE_VOLUME && !mute_reg && !collapsed_reg
      && base_reg == POS_LOUDEST |=> base_reg == POS_LOUDEST && $stable(off_reg);
  endproperty
  a_loudest: assert property (p_loudest) else $error("loudest tap exceeded");
  property p_collapse;
    @(posedge aclk) disable iff (!aresetn)
      step_dn && mode_reg == MODE_VOLUME && !mute_reg && !mute_press
      && base_reg == POS_QUIETEST |=> des[0] == POS_MUTE && des[1] == POS_MUTE;
  endproperty
  a_collapse: assert property (p_collapse) else $error("no mute below tap 31");
  property p_timeout;
    @(posedge aclk) disable iff (!aresetn)
      wiper_reg[0] != des[0] && $stable(des[0]) |-> tmr_reg[0] < CNT_W'(TIMEOUT_CYCLES);
  endproperty
  a_timeout: assert property (p_timeout) else $error("wiper wait too long");
  property p_zc_commit;
    @(posedge aclk) disable iff (!aresetn)
      zc2_reg[1] && wiper_reg[1] != des[1] |=> wiper_reg[1] == $past(des[1]);
  endproperty
  a_zc_commit: assert property (p_zc_commit) else $error("zero cross ignored");
  property p_indicator;
    @(posedge aclk) disable iff (!aresetn)
      ##1 balance_indicator_n_oe == ($past(mode_reg) == MODE_BALANCE);
  endproperty
  a_indicator: assert property (p_indicator) else $error("indicator wrong");
  property p_bal_onehot;
    @(posedge aclk) disable iff (!aresetn)
      mode_reg == MODE_BALANCE |=> $onehot(level_bar_n_oe);
  endproperty
  a_bal_onehot: assert property (p_bal_onehot) else $error("balance LED not one-hot");
  property p_both_buttons;
    @(posedge aclk) disable iff (!aresetn)
      both_held |=> $stable(mode_reg) && $stable(mute_reg) && $stable(base_reg);
  endproperty
  a_both_buttons: assert property (p_both_buttons) else $error("double press acted");
  property p_sleep;
    @(posedge aclk) disable iff (!aresetn)
      shutdown_reg |-> des[0] == POS_MUTE && des[1] == POS_MUTE ##1 $stable(base_reg);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep target wrong");
endmodule : evc_top
`default_nettype wire

// File: verif/evc_knob.sv
// Behavioural rotary knob and two pushbuttons facing the volume control.
// Assumes the bench calls its tasks; contacts are pulled up, so idle is high.
`default_nettype none
module evc_knob #(
  parameter int HOLD = 16
) (
  input wire logic aclk,
  output logic encoder_phase_a,
  output logic encoder_phase_b,
  output logic mode_button_n,
  output logic mute_button_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import evc_pkg::*;
  logic [1:0] seq [4] = '{GRAY0, GRAY1, GRAY2, GRAY3};
  int idx = 2;
  // Detent rest position is both contacts open
  initial begin
    {encoder_phase_b, encoder_phase_a} = seq[2];
    mode_button_n = 1'b1;
    mute_button_n = 1'b1;
  end
  // One detent; each state outlives twice the debounce span, spacing kept too
  task automatic step(input logic up);
    idx = up ? (idx + 1) % 4 : (idx + 3) % 4;
    @(posedge aclk);
    {encoder_phase_b, encoder_phase_a} <= seq[idx];
    repeat (HOLD) @(posedge aclk);
  endtask : step
  // Short len models a contact bounce that must not count as a push
  task automatic push(input logic md, input logic mt, input int len);
    @(posedge aclk);
    mode_button_n <= ~md;
    mute_button_n <= ~mt;
    repeat (len) @(posedge aclk);
    mode_button_n <= 1'b1;
    mute_button_n <= 1'b1;
    repeat (HOLD) @(posedge aclk);
  endtask : push
endmodule : evc_knob
`default_nettype wire

// File: verif/tb_evc_top.sv
// Self-checking bench for the volume control: knob, buttons, sleep, AXI4-Lite.
// Assumes short debounce and timeout parameters; a step commits in 40 cycles.
`default_nettype none
module tb_evc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import evc_pkg::*;
  `define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
  typedef struct packed {
    logic [1:0] act;
    logic [5:0] c0;
    logic [5:0] c1;
    logic ind;
    logic [4:0] bar;
  } evc_row_t;
  // Actions: 0 up, 1 down, 2 mode push, 3 mute push
  localparam evc_row_t ROWS [16] = '{
    '{0, 5, 5, 0, 5'h0F}, '{0, 4, 4, 0, 5'h1F}, '{2, 4, 4, 1, 5'h04}, '{0, 5, 4, 1, 5'h08},
    '{1, 4, 4, 1, 5'h04}, '{1, 4, 5, 1, 5'h02}, '{2, 4, 5, 0, 5'h1F}, '{0, 3, 4, 0, 5'h1F},
    '{0, 2, 3, 0, 5'h1F}, '{0, 1, 2, 0, 5'h1F}, '{0, 0, 1, 0, 5'h1F}, '{0, 0, 1, 0, 5'h1F},
    '{3, 32, 32, 0, 5'h00}, '{0, 0, 1, 0, 5'h1F}, '{3, 32, 32, 0, 5'h00}, '{3, 0, 1, 0, 5'h1F}};
  localparam evc_row_t TAIL [6] = '{
    '{1, 31, 31, 0, 5'h00}, '{1, 32, 32, 0, 5'h00}, '{3, 31, 31, 0, 5'h00},
    '{1, 32, 32, 0, 5'h00}, '{0, 31, 31, 0, 5'h00}, '{0, 30, 31, 0, 5'h00}};
  logic aclk, aresetn, encoder_phase_a, encoder_phase_b, mode_button_n, mute_button_n;
  logic sleep_request_n, balance_indicator_n_o, balance_indicator_n_oe;
  logic [1:0] zero_cross, s_axi_bresp, s_axi_rresp, resp;
  logic [4:0] level_bar_n_o, level_bar_n_oe;
  evc_wiper_pair_t wiper_pos;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_fail = 0;
  int check_count = 0;
  evc_top #(.DEBOUNCE_CYCLES(8), .TIMEOUT_CYCLES(20)) DUT (.aclk, .aresetn, .encoder_phase_a,
    .encoder_phase_b, .mode_button_n, .mute_button_n, .sleep_request_n, .zero_cross,
    .balance_indicator_n_o, .balance_indicator_n_oe, .level_bar_n_o, .level_bar_n_oe, .wiper_pos,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  evc_knob knob (.aclk, .encoder_phase_a, .encoder_phase_b, .mode_button_n, .mute_button_n);
  // 25 MHz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Bar level from attenuation 2n dB: one LED fewer per band
  function automatic logic [4:0] bar_exp(input int n);
    if (n <= 4) return 5'h1F;
    if (n <= 9) return 5'h0F;
    if (n <= 14) return 5'h07;
    if (n <= 19) return 5'h03;
    if (n <= 26) return 5'h01;
    return 5'h00;
  endfunction : bar_exp
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // Holds each channel until its own ready edge; response waited for up to 50 cycles, then checked
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        done = 1'b1;
        s_axi_bready <= 1'b0;
      end
    end
    `CHK(done, 1'b1)
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    d = '0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        done = 1'b1;
        s_axi_rready <= 1'b0;
      end
    end
    `CHK(done, 1'b1)
  endtask : axi_rd
  task automatic settle;
    repeat (40) @(posedge aclk);
    #1;
  endtask : settle
  // One knob or button action, then the committed state is compared
  task automatic chk(input evc_row_t r);
    case (r.act)
      2'h0: knob.step(1'b1);
      2'h1: knob.step(1'b0);
      2'h2: knob.push(1'b1, 1'b0, 16);
      default: knob.push(1'b0, 1'b1, 16);
    endcase
    settle();
    `CHK(wiper_pos, {r.c1, r.c0})
    `CHK(balance_indicator_n_oe, r.ind)
    `CHK(level_bar_n_oe, r.bar)
  endtask : chk
  // Hang guard, sized well above the full sequence
  initial begin
    #(60000 * 40);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, zero_cross} = '0;
    s_axi_wstrb = 4'hF;
    sleep_request_n = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    `CHK(wiper_pos, {6'h20, 6'h20})
    `CHK(balance_indicator_n_oe, 1'b0)
    axi_rd(REG_CTRL, rd, resp);
    `CHK(rd, 32'h0)
    settle();
    `CHK(wiper_pos, {6'h06, 6'h06})
    foreach (ROWS[k]) chk(ROWS[k]);
    // Walk down to the quiet end, the bar band changing on the louder wiper
    for (int i = 1; i <= 30; i++) chk('{2'h1, 6'(i), 6'(i + 1), 1'b0, bar_exp(i)});
    foreach (TAIL[k]) chk(TAIL[k]);
    // Zero crossing commits before the timeout; without it the timer does
    zero_cross <= 2'h3;
    knob.step(1'b1);
    @(posedge aclk);
    #1;
    `CHK(wiper_pos, {6'h1E, 6'h1D})
    zero_cross <= 2'h0;
    knob.step(1'b1);
    #1;
    `CHK(wiper_pos, {6'h1E, 6'h1D})
    settle();
    `CHK(wiper_pos, {6'h1D, 6'h1C})
    knob.push(1'b1, 1'b0, 4);
    settle();
    `CHK(balance_indicator_n_oe, 1'b0)
    knob.push(1'b1, 1'b1, 16);
    settle();
    `CHK(balance_indicator_n_oe, 1'b0)
    `CHK(wiper_pos, {6'h1D, 6'h1C})
    sleep_request_n <= 1'b0;
    settle();
    `CHK(wiper_pos, {6'h20, 6'h20})
    axi_rd(REG_STATUS, rd, resp);
    `CHK(rd[2:0], 3'h4)
    sleep_request_n <= 1'b1;
    settle();
    `CHK(wiper_pos, {6'h1D, 6'h1C})
    // Software gate on the knob, plus refused accesses
    axi_wr(REG_CTRL, 32'h1, resp);
    `CHK(resp, AXI_OKAY)
    axi_rd(REG_CTRL, rd, resp);
    `CHK(rd, 32'h1)
    chk('{2'h0, 6'h1C, 6'h1D, 1'b0, 5'h00});
    axi_wr(REG_WIPER, 32'h0, resp);
    `CHK(resp, AXI_SLVERR)
    axi_rd(8'h0C, rd, resp);
    `CHK({rd, resp}, {32'h0, AXI_SLVERR})
    // A write with lane 0 disabled must leave the control bits alone
    s_axi_wstrb <= 4'h0;
    axi_wr(REG_CTRL, 32'h0, resp);
    s_axi_wstrb <= 4'hF;
    `CHK(resp, AXI_OKAY)
    axi_rd(REG_CTRL, rd, resp);
    `CHK(rd, 32'h1)
    axi_wr(REG_CTRL, 32'h0, resp);
    chk('{2'h0, 6'h1B, 6'h1C, 1'b0, 5'h00});
    tally_and_finish();
  end
endmodule : tb_evc_top
`default_nettype wire
